/* inc/hmp_params.svh */
`ifndef HMP_PARAMS_SVH
`define HMP_PARAMS_SVH

// ----------------------------------------
// Port geometry
// ----------------------------------------
`define HMP_ADDR_W 8
`define HMP_DATA_W 8
// ----------------------------------------
// Float control bit position in internal control byte
// ----------------------------------------
`define HMP_FLOAT_BIT 2
`define HMP_CTRL_ADDR 8'hC2
`define HMP_CTRL_RESET 8'h00
// ----------------------------------------
// Arbiter clock derived from sys_clk (200 MHz / 10 = 20 MHz)
// ----------------------------------------
`define HMP_SYS_MHZ 200
`define HMP_ARB_MHZ 20
`define HMP_ARB_DIV (`HMP_SYS_MHZ / `HMP_ARB_MHZ)
// ----------------------------------------
// Host side wait between phases, in sys_clk cycles
// ----------------------------------------
`define HMP_HOST_SETUP 2

`endif

/* inc/hmp_pkg.sv */
package hmp_pkg;
	typedef enum logic [2:0] {
		HMP_DEV_IDLE = 3'b000,
		HMP_DEV_WAIT = 3'b001,
		HMP_DEV_ACC = 3'b010,
		HMP_DEV_DONE = 3'b011,
		HMP_DEV_REL = 3'b100
	} hmp_dev_state_t;

	typedef enum logic [2:0] {
		HMP_HST_IDLE = 3'b000,
		HMP_HST_SETUP = 3'b001,
		HMP_HST_STROBE = 3'b010,
		HMP_HST_WAIT = 3'b011,
		HMP_HST_END = 3'b100
	} hmp_host_state_t;
endpackage

/* inc/hmp_if.sv */
`timescale 1ns/10ps
interface hmp_if;
	logic [7:0] addr;
	logic wr_n;
	logic rd_n;
	logic sel_n;
	logic bus_style_select;
	logic [7:0] data_host_o;
	logic data_host_oe;
	logic [7:0] data_dev_o;
	logic data_dev_oe;
	logic transfer_ack_o;
	logic transfer_ack_oe;
	logic irq_o;
	logic irq_oe;

	modport dev (
		input addr, wr_n, rd_n, sel_n, bus_style_select, data_host_o, data_host_oe,
		output data_dev_o, data_dev_oe, transfer_ack_o, transfer_ack_oe, irq_o, irq_oe
	);
	modport host (
		output addr, wr_n, rd_n, sel_n, bus_style_select, data_host_o, data_host_oe,
		input data_dev_o, data_dev_oe, transfer_ack_o, transfer_ack_oe, irq_o, irq_oe
	);
endinterface

/* hw/hmp_device.sv */
`timescale 1ns/10ps
`include "hmp_params.svh"
module hmp_device
	import hmp_pkg::*;
#(
	parameter int DEPTH = 256
) (
	input wire logic sys_clk,
	input wire logic resetn,
	hmp_if.dev bus,
	input wire logic alert_req,
	output logic alert_float_enable,
	output logic busy
);
	// Eight address lines reach exactly 256 words
	if (DEPTH != 256) begin : g_depth_check
		$error("DEPTH must be 256");
	end

	// ----------------------------------------
	// Arbiter clock enable
	// ----------------------------------------
	logic [7:0] div_q, div_d;
	logic arb_tick;
	always_comb begin
		div_d = (div_q == 8'(`HMP_ARB_DIV - 1)) ? 8'h00 : div_q + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (!resetn) div_q <= 8'h00;
		else div_q <= div_d;
	end
	assign arb_tick = (div_q == 8'h00);

	// ----------------------------------------
	// Strobe synchronisers
	// ----------------------------------------
	logic [2:0] s1_q, s2_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s1_q <= 3'h7;
			s2_q <= 3'h7;
		end else begin
			s1_q <= {bus.sel_n, bus.rd_n, bus.wr_n};
			s2_q <= s1_q;
		end
	end
	logic sel_s, rd_s, wr_s, dir_mode;
	assign dir_mode = bus.bus_style_select;
	assign sel_s = !s2_q[2];
	// Direction mode ignores the write strobe
	assign rd_s = dir_mode ? s2_q[1] : !s2_q[1];
	assign wr_s = dir_mode ? !s2_q[1] : !s2_q[0];
	logic req;
	assign req = sel_s && (rd_s || wr_s);

	// ----------------------------------------
	// RAM and control byte
	// ----------------------------------------
	logic [7:0] mem [DEPTH];
	hmp_dev_state_t st_q, st_d;
	logic [7:0] rdat_q, rdat_d;
	logic is_rd_q, is_rd_d;
	logic ack_q, ack_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic do_wr;

	always_comb begin
		st_d = st_q;
		rdat_d = rdat_q;
		is_rd_d = is_rd_q;
		ack_d = ack_q;
		ctrl_d = ctrl_q;
		do_wr = 1'b0;
		case (st_q)
			HMP_DEV_IDLE: begin
				ack_d = 1'b0;
				if (req) begin
					is_rd_d = rd_s;
					st_d = HMP_DEV_WAIT;
				end
			end
			HMP_DEV_WAIT: begin
				if (!req) st_d = HMP_DEV_IDLE;
				else if (arb_tick) st_d = HMP_DEV_ACC;
			end
			HMP_DEV_ACC: begin
				if (is_rd_q) begin
					rdat_d = mem[bus.addr];
				end else begin
					do_wr = 1'b1;
					if (bus.addr == `HMP_CTRL_ADDR) ctrl_d = bus.data_host_o;
				end
				st_d = HMP_DEV_DONE;
			end
			HMP_DEV_DONE: begin
				ack_d = 1'b1;
				st_d = HMP_DEV_REL;
			end
			HMP_DEV_REL: begin
				if (!req) begin
					ack_d = 1'b0;
					st_d = HMP_DEV_IDLE;
				end
			end
			default: st_d = HMP_DEV_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_q <= HMP_DEV_IDLE;
			rdat_q <= 8'h00;
			is_rd_q <= 1'b0;
			ack_q <= 1'b0;
			ctrl_q <= `HMP_CTRL_RESET;
		end else begin
			st_q <= st_d;
			rdat_q <= rdat_d;
			is_rd_q <= is_rd_d;
			ack_q <= ack_d;
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (do_wr) mem[bus.addr] <= bus.data_host_o;
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic [7:0] dout_q;
	logic doe_q, tack_q, tack_oe_q, irq_q, irq_oe_q, flt_q, busy_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dout_q <= 8'h00;
			doe_q <= 1'b0;
			tack_q <= 1'b0;
			tack_oe_q <= 1'b0;
			irq_q <= 1'b0;
			irq_oe_q <= 1'b0;
			flt_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			dout_q <= rdat_d;
			doe_q <= sel_s && rd_s && is_rd_d && (st_d != HMP_DEV_IDLE);
			// Strobe mode: ready high when done; direction mode: ack low when done
			tack_q <= dir_mode ? !ack_d : ack_d;
			tack_oe_q <= dir_mode ? 1'b1 : sel_s;
			flt_q <= ctrl_d[`HMP_FLOAT_BIT];
			if (dir_mode) begin
				irq_q <= !alert_req;
				irq_oe_q <= alert_req || !ctrl_d[`HMP_FLOAT_BIT];
			end else begin
				irq_q <= alert_req;
				irq_oe_q <= alert_req || !ctrl_d[`HMP_FLOAT_BIT];
			end
			busy_q <= (st_d != HMP_DEV_IDLE);
		end
	end
	assign bus.data_dev_o = dout_q;
	assign bus.data_dev_oe = doe_q;
	assign bus.transfer_ack_o = tack_q;
	assign bus.transfer_ack_oe = tack_oe_q;
	assign bus.irq_o = irq_q;
	assign bus.irq_oe = irq_oe_q;
	assign alert_float_enable = flt_q;
	assign busy = busy_q;
endmodule

/* hw/hmp_host.sv */
`timescale 1ns/10ps
`include "hmp_params.svh"
module hmp_host
	import hmp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	hmp_if.host bus,
	input wire logic style,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic irq_active
);
	hmp_host_state_t st_q, st_d;
	logic [7:0] a_q, a_d, w_q, w_d, r_q, r_d;
	logic we_q, we_d, rv_q, rv_d, free_q, free_d, irq_q;
	logic [3:0] cnt_q, cnt_d;
	logic sel_q, sel_d, stb_q, stb_d, m_q, m_d;
	logic sel_n_q, wr_n_q, rd_n_q, hoe_q;
	logic done;

	// Done level depends on style
	assign done = bus.transfer_ack_oe && (m_q ? !bus.transfer_ack_o : bus.transfer_ack_o);

	always_comb begin
		st_d = st_q;
		a_d = a_q;
		w_d = w_q;
		r_d = r_q;
		we_d = we_q;
		rv_d = 1'b0;
		free_d = 1'b0;
		cnt_d = cnt_q;
		sel_d = sel_q;
		stb_d = stb_q;
		m_d = m_q;
		case (st_q)
			HMP_HST_IDLE: begin
				free_d = 1'b1;
				m_d = style;
				if (req_valid && free_q) begin
					a_d = req_addr;
					w_d = req_wdata;
					we_d = req_write;
					free_d = 1'b0;
					cnt_d = 4'h0;
					st_d = HMP_HST_SETUP;
				end
			end
			HMP_HST_SETUP: begin
				sel_d = 1'b1;
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == 4'(`HMP_HOST_SETUP)) st_d = HMP_HST_STROBE;
			end
			HMP_HST_STROBE: begin
				stb_d = 1'b1;
				st_d = HMP_HST_WAIT;
			end
			HMP_HST_WAIT: begin
				if (done) begin
					r_d = bus.data_dev_o;
					stb_d = 1'b0;
					sel_d = 1'b0;
					rv_d = !we_q;
					st_d = HMP_HST_END;
				end
			end
			HMP_HST_END: begin
				if (!done) st_d = HMP_HST_IDLE;
			end
			default: st_d = HMP_HST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_q <= HMP_HST_IDLE;
			a_q <= 8'h00;
			w_q <= 8'h00;
			r_q <= 8'h00;
			we_q <= 1'b0;
			rv_q <= 1'b0;
			free_q <= 1'b0;
			cnt_q <= 4'h0;
			sel_q <= 1'b0;
			stb_q <= 1'b0;
			m_q <= 1'b0;
			irq_q <= 1'b0;
			sel_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			hoe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			a_q <= a_d;
			w_q <= w_d;
			r_q <= r_d;
			we_q <= we_d;
			rv_q <= rv_d;
			free_q <= free_d;
			// Pin levels registered from next values, no decode glitches
			sel_n_q <= !sel_d;
			wr_n_q <= m_d ? 1'b1 : !(stb_d && we_d);
			rd_n_q <= m_d ? !we_d : !(stb_d && !we_d);
			hoe_q <= sel_d && we_d;
			cnt_q <= cnt_d;
			sel_q <= sel_d;
			stb_q <= stb_d;
			m_q <= m_d;
			irq_q <= bus.irq_oe && (m_q ? !bus.irq_o : bus.irq_o);
		end
	end

	assign bus.addr = a_q;
	assign bus.sel_n = sel_n_q;
	assign bus.bus_style_select = m_q;
	assign bus.wr_n = wr_n_q;
	assign bus.rd_n = rd_n_q;
	assign bus.data_host_o = w_q;
	assign bus.data_host_oe = hoe_q;
	assign req_ready = free_q;
	assign rsp_valid = rv_q;
	assign rsp_rdata = r_q;
	assign irq_active = irq_q;
endmodule

/* bench/hmp_asserts.sv */
`timescale 1ns/10ps
module hmp_asserts (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic bus_style_select,
	input wire logic data_host_oe,
	input wire logic data_dev_oe,
	input wire logic transfer_ack_o,
	input wire logic transfer_ack_oe,
	input wire logic irq_o,
	input wire logic irq_oe,
	input wire logic alert_req,
	input wire logic alert_float_enable
);
	logic req;
	logic ack;
	assign req = !sel_n && (bus_style_select || !rd_n || !wr_n);
	assign ack = transfer_ack_oe && (transfer_ack_o ^ bus_style_select);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ----
	// Transfer handshake, data bus drive and irq pin
	// ----
	sequence s_start;
		$rose(req);
	endsequence
	sequence s_done;
		##[3:40] ack;
	endsequence
	chk_ack_sync: assert property (s_start |-> !ack [*2])
		else $error("ack before sync");
	chk_ack_bound: assert property (s_start |-> s_done)
		else $error("ack missing");
	chk_ack_hold: assert property (ack && req |=> ack || !req)
		else $error("ack dropped early");
	chk_dev_oe_read: assert property ($rose(data_dev_oe) |-> !sel_n && (rd_n == bus_style_select))
		else $error("data driven outside read");
	chk_no_fight: assert property (!(data_dev_oe && data_host_oe))
		else $error("data contention");
	chk_irq_drive: assert property ((alert_req || !alert_float_enable) [*4] |-> irq_oe)
		else $error("irq not driven");
	chk_irq_float: assert property ((!alert_req && alert_float_enable) [*4] |-> !irq_oe)
		else $error("irq not floated");
	chk_irq_pol: assert property ((irq_oe && $stable(alert_req) && $stable(bus_style_select)) [*4]
		|-> irq_o == (alert_req ^ bus_style_select))
		else $error("irq level wrong");
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 1'b0;
	logic resetn, style, req_valid, req_write, alert_req;
	logic [7:0] req_addr, req_wdata, rsp_rdata;
	logic req_ready, rsp_valid, irq_active, alert_float_enable, busy;
	int error_cnt = 0;
	int check_count = 0;
	hmp_if bus_if();
	hmp_host hmp_host_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(bus_if), .style(style),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_active(irq_active));
	hmp_device hmp_device_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(bus_if), .alert_req(alert_req),
		.alert_float_enable(alert_float_enable), .busy(busy));
	hmp_asserts hmp_asserts_inst (.sys_clk(sys_clk), .resetn(resetn), .sel_n(bus_if.sel_n),
		.rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .bus_style_select(bus_if.bus_style_select),
		.data_host_oe(bus_if.data_host_oe), .data_dev_oe(bus_if.data_dev_oe),
		.transfer_ack_o(bus_if.transfer_ack_o), .transfer_ack_oe(bus_if.transfer_ack_oe),
		.irq_o(bus_if.irq_o), .irq_oe(bus_if.irq_oe), .alert_req(alert_req),
		.alert_float_enable(alert_float_enable));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ----
	// Access tasks
	// ----
	task report_and_stop;
		$display("Checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			$display("Error at %0t: expected %h got %h", $time, exp, got);
			error_cnt++;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		repeat (200) begin
			@(negedge sys_clk);
			if (req_ready === 1'b1) break;
		end
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		got = 8'hXX;
		xfer(1'b0, a, 8'h00);
		repeat (200) begin
			@(negedge sys_clk);
			if (rsp_valid === 1'b1) begin
				got = rsp_rdata;
				break;
			end
		end
		chk(exp, got);
	endtask
	task irq_step(input logic v);
		@(posedge sys_clk);
		alert_req <= v;
		repeat (60) begin
			@(negedge sys_clk);
			if (irq_active === v) break;
		end
		chk({7'h00, v}, {7'h00, irq_active});
	endtask
	initial begin
		resetn = 1'b0;
		style = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 8'h00;
		req_wdata = 8'h00;
		alert_req = 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b0;
		@(posedge sys_clk);
		resetn <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk);
			style <= m[0];
			xfer(1'b1, 8'h00, 8'hA5 ^ {7'h00, m[0]});
			xfer(1'b1, 8'hFF, 8'h5A);
			xfer(1'b1, 8'h7E, 8'h3C);
			rd(8'h00, 8'hA5 ^ {7'h00, m[0]});
			rd(8'hFF, 8'h5A);
			rd(8'h7E, 8'h3C);
			irq_step(1'b1);
			irq_step(1'b0);
			chk(8'h00, {7'h00, busy});
			xfer(1'b1, 8'hC2, 8'h04);
			rd(8'hC2, 8'h04);
			chk(8'h01, {7'h00, alert_float_enable});
			irq_step(1'b1);
			irq_step(1'b0);
			xfer(1'b1, 8'hC2, 8'h00);
		end
		report_and_stop();
	end
	initial begin
		#100000;
		error_cnt++;
		report_and_stop();
	end
endmodule
